/* pkg/rpis_defs.svh */
`ifndef RPIS_DEFS_SVH
`define RPIS_DEFS_SVH

// register offsets
`define RPIS_ADDR_ISR_HI 8'hDA
`define RPIS_ADDR_ISR_LO 8'hDB
`define RPIS_ADDR_IE_HI 8'hD8
`define RPIS_ADDR_IE_LO 8'hD9

// reset values
`define RPIS_RESET_BYTE 8'h00
`define RPIS_RESET_BIT 1'b0

// implemented bits; reserved bits read zero
`define RPIS_HI_MASK 8'h07
`define RPIS_LO_MASK 8'h77

// which detailed status read clears which flag
`define RPIS_HI_CLR_FIRST 8'h03
`define RPIS_HI_CLR_SECOND 8'h04
`define RPIS_LO_CLR_FIRST 8'h07
`define RPIS_LO_CLR_SECOND 8'h70

// upper register bit positions
`define RPIS_HI_ENC_BIT 2
`define RPIS_HI_SEQ_BIT 1
`define RPIS_HI_CRC_BIT 0

// lower register bit positions
`define RPIS_LO_LEN_BIT 6
`define RPIS_LO_CNT_BIT 5
`define RPIS_LO_OVF_BIT 4
`define RPIS_LO_PAR_BIT 2
`define RPIS_LO_PORT_BIT 1
`define RPIS_LO_LOCK_BIT 0

// change detector lanes
`define RPIS_CHG_LOCK 0
`define RPIS_CHG_PORT 1

`endif

/* pkg/rpis_pkg.sv */
`default_nettype none
package rpis_pkg;

	typedef struct packed {
		logic irq;
		logic rd_valid;
		logic [7:0] rdata;
		logic [7:0] en_hi;
		logic [7:0] en_lo;
	} rpis_top_state_type;

	typedef struct packed {
		logic [7:0] flags;
	} rpis_flag_state_type;

	typedef struct packed {
		logic armed;
		logic [1:0] prev;
	} rpis_chg_state_type;

endpackage
`default_nettype wire

/* hdl/rpis_sticky_flags.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rpis_defs.svh"

module rpis_sticky_flags #(
	parameter logic [7:0] VALID_MASK = `RPIS_HI_MASK
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// event and clear strobes
	input wire logic [7:0] set_bits,
	input wire logic [7:0] clear_bits,
	// latched flags
	output logic [7:0] flags
);

	rpis_pkg::rpis_flag_state_type state_ff;
	rpis_pkg::rpis_flag_state_type nxt_state;

	// set beats clear so an event in the clearing cycle survives
	always_comb begin
		nxt_state = state_ff;
		nxt_state.flags = ((state_ff.flags & ~clear_bits) | set_bits) & VALID_MASK;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_ff.flags <= `RPIS_RESET_BYTE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign flags = state_ff.flags;

endmodule
`default_nettype wire

/* hdl/rpis_change_detect.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rpis_defs.svh"

module rpis_change_detect (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// watched levels
	input wire logic [1:0] levels,
	// one-cycle change pulses
	output logic [1:0] changed
);

	rpis_pkg::rpis_chg_state_type state_ff;
	rpis_pkg::rpis_chg_state_type nxt_state;

	always_comb begin
		nxt_state = state_ff;
		nxt_state.armed = 1'b1;
		nxt_state.prev = levels;
	end

	// first cycle after reset only samples, so a high level is not a change
	assign changed = state_ff.armed ? (levels ^ state_ff.prev) : 2'h0;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_ff.armed <= `RPIS_RESET_BIT;
			state_ff.prev <= {2{`RPIS_RESET_BIT}};
		end else begin
			state_ff <= nxt_state;
		end
	end

endmodule
`default_nettype wire

/* hdl/rpis_top.sv */
// How it works
// - encoding error sets upper bit 2, second-read clears
// - sequence error sets upper bit 1, first-read clears
// - control crc error sets upper bit 0
// - line length change sets lower bit 6
// - line count change sets lower bit 5
// - receive overflow sets lower bit 4
// - parity error sets lower bit 2
// - port-valid change sets lower bit 1
// - upper reserved bits read zero, reset zero
// - lock enable routes lock change to interrupt
// - lock change sets lower bit 0
// - parity enable routes parity error to interrupt
`timescale 1ns/1ps
`default_nettype none
`include "rpis_defs.svh"

module rpis_top (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// register access
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rd_valid,
	// reads of the detailed status registers
	input wire logic status_first_read,
	input wire logic status_second_read,
	// receiver event pulses
	input wire logic encoding_error_event,
	input wire logic sequence_error_event,
	input wire logic crc_error_event,
	input wire logic line_length_change_event,
	input wire logic line_count_change_event,
	input wire logic overflow_event,
	input wire logic parity_error_event,
	// receiver levels
	input wire logic port_valid,
	input wire logic lock_status,
	// interrupt
	output logic irq
);

	rpis_pkg::rpis_top_state_type st_ff;
	rpis_pkg::rpis_top_state_type nxt_st;

	logic [7:0] set_hi;
	logic [7:0] set_lo;
	logic [7:0] clr_hi;
	logic [7:0] clr_lo;
	logic [7:0] flags_hi;
	logic [7:0] flags_lo;
	logic [1:0] changed;

	function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic [7:0] fhi,
		input logic [7:0] flo, input logic [7:0] ehi, input logic [7:0] elo);
		logic [7:0] r;
		r = `RPIS_RESET_BYTE;
		case (addr)
			`RPIS_ADDR_ISR_HI: r = fhi & `RPIS_HI_MASK;
			`RPIS_ADDR_ISR_LO: r = flo & `RPIS_LO_MASK;
			`RPIS_ADDR_IE_HI: r = ehi;
			`RPIS_ADDR_IE_LO: r = elo;
			default: r = `RPIS_RESET_BYTE;
		endcase
		return r;
	endfunction

	rpis_change_detect u_chg (
		.core_clk(core_clk),
		.reset(reset),
		.levels({port_valid, lock_status}),
		.changed(changed)
	);

	always_comb begin
		set_hi = `RPIS_RESET_BYTE;
		set_hi[`RPIS_HI_ENC_BIT] = encoding_error_event;
		set_hi[`RPIS_HI_SEQ_BIT] = sequence_error_event;
		set_hi[`RPIS_HI_CRC_BIT] = crc_error_event;
		set_lo = `RPIS_RESET_BYTE;
		set_lo[`RPIS_LO_LEN_BIT] = line_length_change_event;
		set_lo[`RPIS_LO_CNT_BIT] = line_count_change_event;
		set_lo[`RPIS_LO_OVF_BIT] = overflow_event;
		set_lo[`RPIS_LO_PAR_BIT] = parity_error_event;
		set_lo[`RPIS_LO_PORT_BIT] = changed[`RPIS_CHG_PORT];
		set_lo[`RPIS_LO_LOCK_BIT] = changed[`RPIS_CHG_LOCK];
	end

	// clearing is tied to the detailed status reads, not to reads of these registers
	always_comb begin
		clr_hi = (status_first_read ? `RPIS_HI_CLR_FIRST : `RPIS_RESET_BYTE)
			| (status_second_read ? `RPIS_HI_CLR_SECOND : `RPIS_RESET_BYTE);
		clr_lo = (status_first_read ? `RPIS_LO_CLR_FIRST : `RPIS_RESET_BYTE)
			| (status_second_read ? `RPIS_LO_CLR_SECOND : `RPIS_RESET_BYTE);
	end

	rpis_sticky_flags #(
		.VALID_MASK(`RPIS_HI_MASK)
	) u_flags_hi (
		.core_clk(core_clk),
		.reset(reset),
		.set_bits(set_hi),
		.clear_bits(clr_hi),
		.flags(flags_hi)
	);

	rpis_sticky_flags #(
		.VALID_MASK(`RPIS_LO_MASK)
	) u_flags_lo (
		.core_clk(core_clk),
		.reset(reset),
		.set_bits(set_lo),
		.clear_bits(clr_lo),
		.flags(flags_lo)
	);

	always_comb begin
		nxt_st = st_ff;
		nxt_st.rd_valid = 1'b0;
		if (reg_wr) begin
			case (reg_addr)
				`RPIS_ADDR_IE_HI: nxt_st.en_hi = reg_wdata & `RPIS_HI_MASK;
				`RPIS_ADDR_IE_LO: nxt_st.en_lo = reg_wdata & `RPIS_LO_MASK;
				default: nxt_st = nxt_st;
			endcase
		end
		if (reg_rd) begin
			nxt_st.rd_valid = 1'b1;
			nxt_st.rdata = read_mux(reg_addr, flags_hi, flags_lo, st_ff.en_hi, st_ff.en_lo);
		end
		// one cycle behind the flags, in exchange for a flop-driven pin
		nxt_st.irq = |((flags_hi & st_ff.en_hi) | (flags_lo & st_ff.en_lo));
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			st_ff.irq <= `RPIS_RESET_BIT;
			st_ff.rd_valid <= `RPIS_RESET_BIT;
			st_ff.rdata <= `RPIS_RESET_BYTE;
			st_ff.en_hi <= `RPIS_RESET_BYTE;
			st_ff.en_lo <= `RPIS_RESET_BYTE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign irq = st_ff.irq;
	assign reg_rdata = st_ff.rdata;
	assign reg_rd_valid = st_ff.rd_valid;

	enc_flag_set_a: assert property (
		@(posedge core_clk) disable iff (reset)
		encoding_error_event |=> flags_hi[`RPIS_HI_ENC_BIT])
		else $error("encoding error flag not set");

	enc_flag_clear_a: assert property (
		@(posedge core_clk) disable iff (reset)
		status_second_read && !encoding_error_event |=> !flags_hi[`RPIS_HI_ENC_BIT])
		else $error("encoding error flag not cleared");

	seq_flag_life_a: assert property (
		@(posedge core_clk) disable iff (reset)
		sequence_error_event ##1 (!status_first_read && !sequence_error_event)
		|=> flags_hi[`RPIS_HI_SEQ_BIT])
		else $error("sequence error flag lost before clear");

	seq_flag_clear_a: assert property (
		@(posedge core_clk) disable iff (reset)
		status_first_read && !sequence_error_event |=> !flags_hi[`RPIS_HI_SEQ_BIT])
		else $error("sequence error flag not cleared");

	crc_flag_set_a: assert property (
		@(posedge core_clk) disable iff (reset)
		crc_error_event && status_first_read |=> flags_hi[`RPIS_HI_CRC_BIT])
		else $error("crc flag lost to clear");

	len_flag_track_a: assert property (
		@(posedge core_clk) disable iff (reset)
		flags_lo[`RPIS_LO_LEN_BIT] && !$past(flags_lo[`RPIS_LO_LEN_BIT])
		|-> $past(line_length_change_event))
		else $error("line length flag set without cause");

	cnt_flag_clear_a: assert property (
		@(posedge core_clk) disable iff (reset)
		status_second_read && !line_count_change_event |=> !flags_lo[`RPIS_LO_CNT_BIT])
		else $error("line count flag not cleared");

	ovf_flag_hold_a: assert property (
		@(posedge core_clk) disable iff (reset)
		flags_lo[`RPIS_LO_OVF_BIT] && !status_second_read |=> flags_lo[`RPIS_LO_OVF_BIT])
		else $error("overflow flag dropped without clear");

	par_flag_clear_a: assert property (
		@(posedge core_clk) disable iff (reset)
		status_first_read && !parity_error_event |=> !flags_lo[`RPIS_LO_PAR_BIT])
		else $error("parity flag not cleared");

	port_chg_flag_a: assert property (
		@(posedge core_clk) disable iff (reset)
		changed[`RPIS_CHG_PORT] |=> flags_lo[`RPIS_LO_PORT_BIT])
		else $error("port valid change not latched");

	hi_reserved_zero_a: assert property (
		@(posedge core_clk) disable iff (reset)
		reg_rd && reg_addr == `RPIS_ADDR_ISR_HI |=> reg_rd_valid && reg_rdata[7:3] == 5'h0
		&& reg_rdata[2:0] == $past(flags_hi[2:0]))
		else $error("upper status read wrong");

	lock_irq_path_a: assert property (
		@(posedge core_clk) disable iff (reset)
		flags_lo[`RPIS_LO_LOCK_BIT] && st_ff.en_lo[`RPIS_LO_LOCK_BIT] |=> irq)
		else $error("enabled lock change gave no interrupt");

	lock_flag_set_a: assert property (
		@(posedge core_clk) disable iff (reset)
		changed[`RPIS_CHG_LOCK] ##1 !status_first_read |-> flags_lo[`RPIS_LO_LOCK_BIT])
		else $error("lock change not latched");

	par_irq_path_a: assert property (
		@(posedge core_clk) disable iff (reset)
		parity_error_event && st_ff.en_lo[`RPIS_LO_PAR_BIT] && !reg_wr |=> ##1 irq)
		else $error("enabled parity error gave no interrupt");

	irq_quiet_a: assert property (
		@(posedge core_clk) disable iff (reset)
		((flags_hi & st_ff.en_hi) == 8'h00) && ((flags_lo & st_ff.en_lo) == 8'h00) |=> !irq)
		else $error("interrupt without enabled flag");

	seq_flag_set_a: assert property (
		@(posedge core_clk) disable iff (reset)
		sequence_error_event |=> flags_hi[`RPIS_HI_SEQ_BIT])
		else $error("sequence error flag not set");

	crc_flag_clear_a: assert property (
		@(posedge core_clk) disable iff (reset)
		status_first_read && !crc_error_event |=> !flags_hi[`RPIS_HI_CRC_BIT])
		else $error("crc flag not cleared");

	len_flag_clear_a: assert property (
		@(posedge core_clk) disable iff (reset)
		status_second_read && !line_length_change_event |=> !flags_lo[`RPIS_LO_LEN_BIT])
		else $error("line length flag not cleared");

	cnt_flag_set_a: assert property (
		@(posedge core_clk) disable iff (reset)
		line_count_change_event |=> flags_lo[`RPIS_LO_CNT_BIT])
		else $error("line count flag not set");

	ovf_flag_set_a: assert property (
		@(posedge core_clk) disable iff (reset)
		overflow_event |=> flags_lo[`RPIS_LO_OVF_BIT])
		else $error("overflow flag not set");

	par_flag_set_a: assert property (
		@(posedge core_clk) disable iff (reset)
		parity_error_event |=> flags_lo[`RPIS_LO_PAR_BIT])
		else $error("parity flag not set");

	port_flag_clear_a: assert property (
		@(posedge core_clk) disable iff (reset)
		status_first_read && !changed[`RPIS_CHG_PORT] |=> !flags_lo[`RPIS_LO_PORT_BIT])
		else $error("port valid change flag not cleared");

	lo_status_read_a: assert property (
		@(posedge core_clk) disable iff (reset)
		reg_rd && reg_addr == `RPIS_ADDR_ISR_LO |=> reg_rd_valid && reg_rdata == $past(flags_lo)
		&& (reg_rdata & ~`RPIS_LO_MASK) == `RPIS_RESET_BYTE)
		else $error("lower status read wrong");

	lock_flag_clear_a: assert property (
		@(posedge core_clk) disable iff (reset)
		status_first_read && !changed[`RPIS_CHG_LOCK] |=> !flags_lo[`RPIS_LO_LOCK_BIT])
		else $error("lock change flag not cleared");

	enable_reset_a: assert property (
		@(posedge core_clk)
		reset |=> st_ff.en_hi == `RPIS_RESET_BYTE && st_ff.en_lo == `RPIS_RESET_BYTE && !irq)
		else $error("enables or interrupt not reset");

	flags_reset_a: assert property (
		@(posedge core_clk)
		reset |=> flags_hi == `RPIS_RESET_BYTE && flags_lo == `RPIS_RESET_BYTE)
		else $error("status flags not reset");

	rdata_hold_a: assert property (
		@(posedge core_clk) disable iff (reset)
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");

	en_write_a: assert property (
		@(posedge core_clk) disable iff (reset)
		reg_wr && reg_addr == `RPIS_ADDR_IE_LO |=> st_ff.en_lo == ($past(reg_wdata) & `RPIS_LO_MASK))
		else $error("lower enable write lost");

	rd_valid_pulse_a: assert property (
		@(posedge core_clk) disable iff (reset)
		!reg_rd |=> !reg_rd_valid)
		else $error("read valid without a read");

endmodule
`default_nettype wire

/* verif/rpis_host.sv */
`timescale 1ns/1ps
`default_nettype none

module rpis_host (
	// register port
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	// detailed status reads
	output logic status_first_read,
	output logic status_second_read
);
	// one host cycle per call; half the time the mapped bytes, otherwise any offset
	task automatic cyc(input logic [31:0] r);
		reg_rd = r[0];
		reg_wr = &r[3:1];
		reg_addr = r[6] ? r[15:8] : 8'hd8 + {6'h00, r[5:4]};
		reg_wdata = r[23:16];
		// sparse clears, so flags live long enough to be seen
		status_first_read = &r[26:24];
		status_second_read = &r[29:27];
	endtask
endmodule

`default_nettype wire

/* verif/tb_rx_port_interrupt_status.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_rx_port_interrupt_status;
	logic core_clk, reset, reg_wr, reg_rd, reg_rd_valid, irq, s1, s2;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, mhi, mlo, ehi, elo, xr;
	logic [6:0] ev;
	logic [1:0] lv, pv, ch;
	logic irq_e, pend, arm, on;
	logic [31:0] seed, r;
	int error_cnt, n_compared, i;

	rpis_host host (.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.status_first_read(s1), .status_second_read(s2));
	rpis_top dut (.core_clk(core_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
		.status_first_read(s1), .status_second_read(s2), .encoding_error_event(ev[6]),
		.sequence_error_event(ev[5]), .crc_error_event(ev[4]), .line_length_change_event(ev[3]),
		.line_count_change_event(ev[2]), .overflow_event(ev[1]), .parity_error_event(ev[0]),
		.port_valid(lv[1]), .lock_status(lv[0]), .irq(irq));

	always #10 core_clk = ~core_clk;

	task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic cmp1(input logic g, input logic e);
		cmp8({7'h00, g}, {7'h00, e});
	endtask

	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// reference model; reads see the state from before the edge
	always @(posedge core_clk) begin
		pend = reg_rd & ~reset;
		case (reg_addr)
			8'hda: xr = mhi;
			8'hdb: xr = mlo;
			8'hd8: xr = ehi;
			8'hd9: xr = elo;
			default: xr = 8'h00;
		endcase
		irq_e = ~reset & |((mhi & ehi) | (mlo & elo));
		// first edge after reset only samples the levels
		ch = arm ? lv ^ pv : 2'b00;
		pv = lv;
		arm = ~reset;
		// set wins over clear
		mhi = (mhi & ~{5'h00, s2, s1, s1}) | {5'h00, ev[6:4]};
		mlo = (mlo & ~{1'b0, {3{s2}}, 1'b0, {3{s1}}}) | {1'b0, ev[3:1], 1'b0, ev[0], ch};
		if (reg_wr && reg_addr == 8'hd8) ehi = reg_wdata & 8'h07;
		if (reg_wr && reg_addr == 8'hd9) elo = reg_wdata & 8'h77;
		if (reset) {mhi, mlo, ehi, elo} = 32'h0000_0000;
	end

	always @(negedge core_clk) begin
		if (on) begin
			cmp1(irq, irq_e);
			cmp1(reg_rd_valid, pend);
			if (pend) cmp8(reg_rdata, xr);
		end
	end

	initial begin
		#300000;
		error_cnt++;
		results();
	end

	initial begin
		core_clk = 0;
		reset = 1;
		on = 0;
		ev = 0;
		lv = 0;
		error_cnt = 0;
		n_compared = 0;
		seed = 32'hf371_e138;
		host.cyc(32'h0000_0000);
		repeat (16) @(posedge core_clk);
		#1 reset = 0;
		on = 1;
		for (i = 0; i < 6000; i++) begin
			@(posedge core_clk);
			#1;
			// a short reset in mid-run
			if (i == 3000) reset = 1;
			if (i == 3003) reset = 0;
			ev = 7'($random(seed) & $random(seed) & $random(seed));
			r = $random(seed);
			if (r[3:0] == 4'h0) lv[0] = ~lv[0];
			if (r[7:4] == 4'h0) lv[1] = ~lv[1];
			host.cyc($random(seed));
		end
		results();
	end
endmodule

`default_nettype wire
